// ### src/move_unit_params.svh
/*
 * Constants of the prefix and register move unit: instruction field
 * positions, module and index codes, and reset values.
 * Assumes: included by the package and the design file by bare name.
 */
`ifndef MOVE_UNIT_PARAMS_SVH
`define MOVE_UNIT_PARAMS_SVH

// word and byte widths
`define WORD_W      16
`define BYTE_W      8
`define SIGN_BIT    7
`define ZERO_BYTE   8'h00
`define ZERO_WORD   16'h0000

// instruction fields
`define FMT_BIT     15
`define DIDX_HI     14
`define DIDX_LO     12
`define DMOD_HI     11
`define DMOD_LO     8
`define SIDX_HI     7
`define SIDX_LO     4
`define SMOD_HI     3
`define SMOD_LO     0
`define IMM_HI      7
`define IMM_LO      0

// prefix index bits: [2:1] destination index bits 4:3, [0] source index bit 4
`define PIDX_W      3
`define PIDX_DST_HI 2
`define PIDX_DST_LO 1
`define PIDX_SRC    0

// module codes and sub-indices
`define MOD_PREFIX  4'hB
`define MOD_BRANCH  4'hC
`define MOD_SPLIT   4'hD
`define IDX_JUMP    5'h00
`define IDX_WORD    5'h00
`define IDX_HIGH    5'h01
`define IDX_LOW     5'h02
`define IDX_SWAP    5'h03
`define IDX_SEXT    5'h04

// reset values
`define RST_SPLIT   16'h0000

`endif

// ### src/move_unit_pkg.sv
/*
 * Types shared by the prefix and register move unit.
 * Assumes: move_unit_params.svh is on the include path.
 */
`include "move_unit_params.svh"

package move_unit_pkg;

    // one-cycle prefix holding state
    typedef struct packed {
        logic                   written;
        logic [`BYTE_W-1:0]     high;
        logic [`PIDX_W-1:0]     idx;
    } prefix_s;

    // write toward the register file outside
    typedef struct packed {
        logic                   we;
        logic                   wide;
        logic [3:0]             mod;
        logic [4:0]             idx;
        logic [`WORD_W-1:0]     data;
    } dst_wr_s;

    // branch request toward the program counter
    typedef struct packed {
        logic                   take;
        logic                   abs;
        logic [`WORD_W-1:0]     target;
    } branch_s;

endpackage

// ### src/prefix_and_register_move_unit.sv
/*
 * Prefix holding register, byte-split word register and move decode of a
 * 16-bit single-cycle core.
 * Assumes: one instruction word arrives every clock; the register file
 * outside returns src_data/src_wide and dst_wide combinationally for the
 * indices formed from the instruction and src_ext_idx.
 */
// Function
// - every 16-bit instruction word is decoded and completed in one cycle
// - prefix holding register keeps a write for one cycle, then clears to zero
// - 16-bit immediate takes its high byte from prefix, zero without a prefix
// - branch is absolute only if prefix was written just before, else relative
// - destination index above 07h, source above 0Fh, need prefix index bits
// - one prefix write serves both immediate high byte and extended indices
// - 16-bit source into 8-bit destination writes only the low byte
// - byte-split word has separately writable high and low byte registers
// - read-only view of the byte-split word with its bytes exchanged
// - read-only view sign-extending the low byte into the upper bits
// - 8-bit source into 16-bit destination gets prefix byte as high byte
`timescale 1ns/1ns
`include "move_unit_params.svh"

module prefix_and_register_move_unit
    import move_unit_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic [`WORD_W-1:0]  instr,
    input  wire logic [`WORD_W-1:0]  src_data,
    input  wire logic                src_wide,
    input  wire logic                dst_wide,
    output logic                     src_ext_idx,
    output dst_wr_s                  dst_wr,
    output branch_s                  branch,
    output logic [`WORD_W-1:0]       split_word
);

    ////////////////////////////////////////////////////////////////////////
    // state and decode signals

    prefix_s             prefix_hold_q;
    prefix_s             prefix_hold_d;
    dst_wr_s             dst_wr_q;
    branch_s             branch_q;
    logic [`WORD_W-1:0]  byte_split_word_q;

    logic                imm_fmt;
    logic [3:0]          dmod;
    logic [3:0]          smod;
    logic [4:0]          didx;
    logic [4:0]          sidx;
    logic [2:0]          op_didx;
    logic [`WORD_W-1:0]  src_word;
    logic                s_wide;
    logic                d_wide;
    logic [`WORD_W-1:0]  move_word;
    logic [`WORD_W-1:0]  wr_data;
    logic [`WORD_W-1:0]  swapped_word_view;
    logic [`WORD_W-1:0]  sign_ext_low_view;
    logic [`BYTE_W-1:0]  split_high_byte;
    logic [`BYTE_W-1:0]  split_low_byte;
    logic                prefix_wr;
    logic                split_wr;
    logic                jump;
    logic                ext_wr;

    // true when a module/index pair names one local register
    function automatic logic hit(input logic [3:0] m, input logic [4:0] i,
                                 input logic [3:0] wm, input logic [4:0] wi);
        hit = (m == wm) && (i == wi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // field split; the upper index bits exist only through the prefix

    assign imm_fmt  = ~instr[`FMT_BIT];
    assign dmod     = instr[`DMOD_HI:`DMOD_LO];
    assign smod     = instr[`SMOD_HI:`SMOD_LO];
    assign op_didx  = instr[`DIDX_HI:`DIDX_LO];
    assign didx     = {prefix_hold_q.idx[`PIDX_DST_HI:`PIDX_DST_LO], op_didx};
    assign sidx     = {prefix_hold_q.idx[`PIDX_SRC], instr[`SIDX_HI:`SIDX_LO]};

    // views of the byte-split word
    assign split_high_byte   = byte_split_word_q[`WORD_W-1:`BYTE_W];
    assign split_low_byte    = byte_split_word_q[`BYTE_W-1:0];
    assign swapped_word_view = {split_low_byte, split_high_byte};
    assign sign_ext_low_view = {{`BYTE_W{split_low_byte[`SIGN_BIT]}}, split_low_byte};

    ////////////////////////////////////////////////////////////////////////
    // source selection: immediate, local view or outside register file

    always_comb begin
        src_word = src_data;
        s_wide   = src_wide;
        if (imm_fmt) begin
            // immediates are byte sources; high byte comes from the prefix
            src_word = {`ZERO_BYTE, instr[`IMM_HI:`IMM_LO]};
            s_wide   = 1'b0;
        end else if (smod == `MOD_SPLIT) begin
            case (sidx)
                `IDX_WORD: begin
                    src_word = byte_split_word_q;
                    s_wide   = 1'b1;
                end
                `IDX_HIGH: begin
                    src_word = {`ZERO_BYTE, split_high_byte};
                    s_wide   = 1'b0;
                end
                `IDX_LOW: begin
                    src_word = {`ZERO_BYTE, split_low_byte};
                    s_wide   = 1'b0;
                end
                `IDX_SWAP: begin
                    src_word = swapped_word_view;
                    s_wide   = 1'b1;
                end
                `IDX_SEXT: begin
                    src_word = sign_ext_low_view;
                    s_wide   = 1'b1;
                end
                default: begin
                    src_word = `ZERO_WORD;
                    s_wide   = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // destination decode and width adaptation

    assign prefix_wr = (dmod == `MOD_PREFIX);
    assign split_wr  = (dmod == `MOD_SPLIT);
    assign jump      = hit(dmod, didx, `MOD_BRANCH, `IDX_JUMP);
    assign ext_wr    = ~prefix_wr & ~split_wr & (dmod != `MOD_BRANCH);
    assign d_wide    = split_wr ? (didx == `IDX_WORD) : dst_wide;

    // byte sources borrow the prefix byte; zero when nothing was prefixed
    assign move_word = s_wide ? src_word
                              : {prefix_hold_q.high, src_word[`BYTE_W-1:0]};
    // a narrow destination sees only the low byte of a wide source
    assign wr_data   = d_wide ? move_word
                              : {`ZERO_BYTE, move_word[`BYTE_W-1:0]};

    ////////////////////////////////////////////////////////////////////////
    // prefix holding register: one write lives exactly one cycle

    always_comb begin
        prefix_hold_d = '0;
        if (prefix_wr) begin
            prefix_hold_d.written = 1'b1;
            prefix_hold_d.high    = src_word[`BYTE_W-1:0];
            prefix_hold_d.idx     = op_didx;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prefix_hold_q <= '0;
        end else begin
            prefix_hold_q <= prefix_hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte-split word; swapped and sign-extended views ignore writes

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_split_word_q <= `RST_SPLIT;
        end else if (split_wr) begin
            case (didx)
                `IDX_WORD: byte_split_word_q <= wr_data;
                `IDX_HIGH: byte_split_word_q[`WORD_W-1:`BYTE_W] <= wr_data[`BYTE_W-1:0];
                `IDX_LOW:  byte_split_word_q[`BYTE_W-1:0] <= wr_data[`BYTE_W-1:0];
                default:   byte_split_word_q <= byte_split_word_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outside write: every instruction completes in its own cycle

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dst_wr_q <= '0;
        end else begin
            dst_wr_q.we   <= ext_wr;
            dst_wr_q.wide <= d_wide;
            dst_wr_q.mod  <= dmod;
            dst_wr_q.idx  <= didx;
            dst_wr_q.data <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // branch: a prefix write, even of 00h, is what makes it absolute

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            branch_q <= '0;
        end else begin
            branch_q.take <= jump;
            branch_q.abs  <= jump & prefix_hold_q.written;
            if (prefix_hold_q.written) begin
                branch_q.target <= move_word;
            end else begin
                // relative offset is the signed low byte
                branch_q.target <= {{`BYTE_W{move_word[`SIGN_BIT]}}, move_word[`BYTE_W-1:0]};
            end
        end
    end

    assign src_ext_idx = prefix_hold_q.idx[`PIDX_SRC];
    assign dst_wr      = dst_wr_q;
    assign branch      = branch_q;
    assign split_word  = byte_split_word_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic [`BYTE_W-1:0]  prefix_high;
    logic [1:0]          prefix_dhi;
    logic [`BYTE_W-1:0]  src_low;
    logic                swap_rd;
    logic                sext_rd;

    assign prefix_high = prefix_hold_q.high;
    assign prefix_dhi  = prefix_hold_q.idx[`PIDX_DST_HI:`PIDX_DST_LO];
    assign src_low     = src_word[`BYTE_W-1:0];
    assign swap_rd     = ~imm_fmt & hit(smod, sidx, `MOD_SPLIT, `IDX_SWAP);
    assign sext_rd     = ~imm_fmt & hit(smod, sidx, `MOD_SPLIT, `IDX_SEXT);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_unprefixed_imm;
        !prefix_hold_q.written && imm_fmt && ext_wr && dst_wide;
    endsequence

    sequence s_zero_prefix_jump;
        (prefix_wr && src_low == `ZERO_BYTE) ##1 jump;
    endsequence

    sequence s_prefix_then_move;
        prefix_wr ##1 (ext_wr && prefix_hold_q.written);
    endsequence

    // mod and low index judged against the raw instruction fields, we against the ext_wr decode
    property p_one_cycle;
        1'b1 |=> dst_wr.we == $past(ext_wr)
                 && dst_wr.mod == $past(instr[`DMOD_HI:`DMOD_LO])
                 && dst_wr.idx[2:0] == $past(instr[`DIDX_HI:`DIDX_LO]);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("move did not complete in one cycle");

    property p_prefix_clear;
        prefix_hold_q.written && !prefix_wr |=> prefix_hold_q == '0;
    endproperty
    a_prefix_clear: assert property (p_prefix_clear) else $error("prefix held beyond one cycle");

    property p_imm_zero_high;
        s_unprefixed_imm |=> dst_wr.data[`WORD_W-1:`BYTE_W] == `ZERO_BYTE;
    endproperty
    a_imm_zero_high: assert property (p_imm_zero_high) else $error("unprefixed immediate high byte not zero");

    property p_branch_rel;
        jump && !prefix_hold_q.written |=> branch.take && !branch.abs;
    endproperty
    a_branch_rel: assert property (p_branch_rel) else $error("unprefixed branch not relative");

    property p_branch_abs_zero;
        s_zero_prefix_jump |=> branch.abs && branch.target[`WORD_W-1:`BYTE_W] == `ZERO_BYTE;
    endproperty
    a_branch_abs_zero: assert property (p_branch_abs_zero) else $error("zero prefix did not make branch absolute");

    property p_ext_index;
        // the prefix came two edges before the registered write shows
        dst_wr.we && dst_wr.idx[4:3] != 2'b00 |-> $past(prefix_wr, 2);
    endproperty
    a_ext_index: assert property (p_ext_index) else $error("extended index without a prefix");

    property p_shared_prefix;
        s_prefix_then_move |=> dst_wr.idx[4:3] == $past(prefix_dhi);
    endproperty
    a_shared_prefix: assert property (p_shared_prefix) else $error("prefix index bits not applied");

    property p_narrow_dst;
        ext_wr && !dst_wide |=> dst_wr.data[`WORD_W-1:`BYTE_W] == `ZERO_BYTE
                                && dst_wr.data[`BYTE_W-1:0] == $past(src_low);
    endproperty
    a_narrow_dst: assert property (p_narrow_dst) else $error("narrow destination not low byte");

    property p_high_byte_only;
        hit(dmod, didx, `MOD_SPLIT, `IDX_HIGH) |=> $stable(byte_split_word_q[`BYTE_W-1:0]);
    endproperty
    a_high_byte_only: assert property (p_high_byte_only) else $error("high byte write touched low byte");

    property p_swap_view;
        swap_rd && ext_wr && dst_wide |=> dst_wr.data == $past(swapped_word_view);
    endproperty
    a_swap_view: assert property (p_swap_view) else $error("swapped view wrong");

    property p_sext_view;
        sext_rd && ext_wr && dst_wide |=> dst_wr.data[`WORD_W-1:`BYTE_W] == {`BYTE_W{dst_wr.data[`SIGN_BIT]}};
    endproperty
    a_sext_view: assert property (p_sext_view) else $error("sign extension wrong");

    property p_concat;
        ext_wr && dst_wide && !s_wide |=> dst_wr.data[`WORD_W-1:`BYTE_W] == $past(prefix_high);
    endproperty
    a_concat: assert property (p_concat) else $error("concatenated high byte not from prefix");

endmodule

// ### tb/testbench.sv
/*
 * Self-checking bench for the prefix and register move unit: prefix
 * immediates, extended indices, branches, byte-split views, mixed widths.
 * Assumes: design and package compiled first; the bench plays the
 * instruction stream and the outside register file itself.
 */
`timescale 1ns/1ns
`include "move_unit_params.svh"

module testbench;
    import move_unit_pkg::*;

    logic                clk;
    logic                rst_b;
    logic [`WORD_W-1:0]  instr;
    logic [`WORD_W-1:0]  src_data;
    logic                src_wide;
    logic                dst_wide;
    logic                src_ext_idx;
    dst_wr_s             dst_wr;
    branch_s             branch;
    logic [`WORD_W-1:0]  split_word;
    int                  num_errors;
    int                  num_checks;

    prefix_and_register_move_unit prefix_and_register_move_unit_i (
        .clk         (clk),
        .rst_b       (rst_b),
        .instr       (instr),
        .src_data    (src_data),
        .src_wide    (src_wide),
        .dst_wide    (dst_wide),
        .src_ext_idx (src_ext_idx),
        .dst_wr      (dst_wr),
        .branch      (branch),
        .split_word  (split_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // clock, 40 ns period
    always #20 clk = ~clk;

    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask

    // present one instruction just after an edge, then let the next edge land
    task automatic run(input logic [15:0] i, input logic [15:0] sd = 16'h0000,
                       input logic sw = 1'b0, input logic dw = 1'b0);
        instr    = i;
        src_data = sd;
        src_wide = sw;
        dst_wide = dw;
        @(posedge clk);
        #1;
    endtask

    // one outside write, checked field by field
    task automatic chk_wr(input logic [3:0] m, input logic [4:0] x, input logic [15:0] d,
                          input logic w = 1'b1);
        chk("dst_wr.we", 32'h1, {31'h0, dst_wr.we});
        chk("dst_wr.wide", {31'h0, w}, {31'h0, dst_wr.wide});
        chk("dst_wr.mod", {28'h0, m}, {28'h0, dst_wr.mod});
        chk("dst_wr.idx", {27'h0, x}, {27'h0, dst_wr.idx});
        chk("dst_wr.data", {16'h0, d}, {16'h0, dst_wr.data});
    endtask

    // verdict, reached from the main sequence or the watchdog
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // prefix index 6 sets dst bits 4:3, byte 12h becomes the high byte
    task automatic t_prefix_imm;
        run(16'h6B12);
        chk("src_ext_idx", 32'h0, {31'h0, src_ext_idx});
        run(16'h0534, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h5, 5'h18, 16'h1234);
        run(16'h0534, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h5, 5'h00, 16'h0034);
    endtask

    // source index bit lives for one instruction only
    task automatic t_src_ext;
        run(16'h1B00);
        chk("src_ext_idx", 32'h1, {31'h0, src_ext_idx});
        run(16'h3D00);
        chk("src_ext_idx", 32'h0, {31'h0, src_ext_idx});
        chk("dst_wr.we", 32'h0, {31'h0, dst_wr.we});
        run(16'h0577, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h5, 5'h00, 16'h0077);
    endtask

    // back-to-back prefix writes: the later one wins
    task automatic t_reload;
        run(16'h0B12);
        run(16'h0B34);
        run(16'h0556, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h5, 5'h00, 16'h3456);
    endtask

    // absolute only after a prefix write, even of 00h
    task automatic t_branch;
        run(16'h0B00);
        run(16'h0C23);
        chk("branch.take", 32'h1, {31'h0, branch.take});
        chk("branch.abs", 32'h1, {31'h0, branch.abs});
        chk("branch.target", 32'h0023, {16'h0, branch.target});
        run(16'h0C23);
        chk("branch.abs", 32'h0, {31'h0, branch.abs});
        chk("branch.target", 32'h0023, {16'h0, branch.target});
        run(16'h0CF0);
        chk("branch.target", 32'hFFF0, {16'h0, branch.target});
        run(16'h0B12);
        run(16'h0C34);
        chk("branch.abs", 32'h1, {31'h0, branch.abs});
        chk("branch.target", 32'h1234, {16'h0, branch.target});
        run(16'h3D00);
        chk("branch.take", 32'h0, {31'h0, branch.take});
    endtask

    // byte-split word: whole, high, low writes and the two read views
    task automatic t_split;
        run(16'h8D01, 16'hA5C3, 1'b1, 1'b0);
        chk("split_word", 32'hA5C3, {16'h0, split_word});
        run(16'h1D5A);
        chk("split_word", 32'h5AC3, {16'h0, split_word});
        run(16'h2D81);
        chk("split_word", 32'h5A81, {16'h0, split_word});
        run(16'h3D00);
        chk("split_word", 32'h5A81, {16'h0, split_word});
        run(16'h4DEE);
        chk("split_word", 32'h5A81, {16'h0, split_word});
        run(16'h813D, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h1, 5'h00, 16'h815A);
        run(16'h814D, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h1, 5'h00, 16'hFF81);
        run(16'h2D7F);
        run(16'h814D, 16'h0000, 1'b0, 1'b1);
        chk_wr(4'h1, 5'h00, 16'h007F);
    endtask

    // mixed-width moves between outside registers
    task automatic t_width;
        run(16'h8101, 16'hBEEF, 1'b1, 1'b0);
        chk_wr(4'h1, 5'h00, 16'h00EF, 1'b0);
        run(16'h0B12);
        run(16'h8101, 16'h0034, 1'b0, 1'b1);
        chk_wr(4'h1, 5'h00, 16'h1234);
        run(16'h8101, 16'h0034, 1'b0, 1'b1);
        chk_wr(4'h1, 5'h00, 16'h0034);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence takes well under 200 cycles
    initial begin
        #(2000 * 40);
        num_errors++;
        results();
    end

    // main sequence
    initial begin
        clk        = 1'b0;
        rst_b      = 1'b0;
        instr      = 16'h3D00;
        src_data   = 16'h0000;
        src_wide   = 1'b0;
        dst_wide   = 1'b0;
        num_errors = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        #1;
        chk("split_word", 32'h0, {16'h0, split_word});
        chk("dst_wr.we", 32'h0, {31'h0, dst_wr.we});
        chk("branch.take", 32'h0, {31'h0, branch.take});
        chk("src_ext_idx", 32'h0, {31'h0, src_ext_idx});
        rst_b = 1'b1;
        t_prefix_imm();
        t_src_ext();
        t_reload();
        t_branch();
        t_split();
        t_width();
        results();
    end

endmodule
